// File: pwmt_map.vh
`ifndef PWMT_MAP_VH
`define PWMT_MAP_VH

// ==========================================================================
// Register indices; the byte address on the bus is four times the index.
// ==========================================================================
`define PWMT_IDX_DUTY3      8'h74
`define PWMT_IDX_DUTY2      8'h75
`define PWMT_IDX_DUTY1      8'h76
`define PWMT_IDX_DUTY0      8'h77
`define PWMT_IDX_WAVE_CTRL  8'h78
`define PWMT_IDX_TIMER_CS   8'h79
`define PWMT_IDX_COUNT      8'h7A
`define PWMT_IDX_RELOAD     8'h7B
`define PWMT_IDX_CAPT_CS    8'h7C
`define PWMT_IDX_CAPT1      8'h7D
`define PWMT_IDX_CAPT2      8'h7E

// ==========================================================================
// Field positions.
// ==========================================================================
`define PWMT_WC_OE_HI       7
`define PWMT_WC_OE_LO       4
`define PWMT_WC_POL_HI      3
`define PWMT_WC_POL_LO      0
`define PWMT_TCS_EXT        7
`define PWMT_TCS_DIV_HI     6
`define PWMT_TCS_DIV_LO     4
`define PWMT_TCS_RUN        3
`define PWMT_TCS_FORCE      2
`define PWMT_TCS_WIE        1
`define PWMT_TCS_WRAP       0
`define PWMT_CCS_EDGE_HI    5
`define PWMT_CCS_EDGE_LO    4
`define PWMT_CCS_IE_HI      3
`define PWMT_CCS_IE_LO      2
`define PWMT_CCS_FLAG_HI    1
`define PWMT_CCS_FLAG_LO    0

// ==========================================================================
// Reset values and counter constants.
// ==========================================================================
`define PWMT_RST_BYTE       8'h00
`define PWMT_CNT_TOP        8'hFF
`define PWMT_PRE_RST        7'h00

`endif

// File: pwmt_monitor.sv
`timescale 1ns/1ps
// ==========================================================================
// Port checks of the timer register block.
// ==========================================================================
module pwmt_monitor #(
  parameter CHANNELS = 4,  // Waveform outputs.
  parameter CAPTURES = 2   // Capture channels.
) (
  // Clock, reset and bus.
  input wire                mclk_in,
  input wire                nrst_in,
  input wire                psel_in,
  input wire                penable_in,
  input wire                pwrite_in,
  input wire [11:0]         paddr_in,
  input wire [31:0]         pwdata_in,
  input wire                pready_out,
  input wire                pslverr_out,
  input wire [31:0]         prdata_out,
  // Timer pins and requests.
  input wire                ext_clk_in,
  input wire [CAPTURES-1:0] capture_pin_in,
  input wire [CHANNELS-1:0] wave_out,
  input wire [CHANNELS-1:0] wave_oe_out,
  input wire                wrap_irq_out,
  input wire [CAPTURES-1:0] capture_irq_out
);
  // High in the access phase of a transfer.
  wire acc = psel_in & penable_in;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);

  a_zero_wait: assert property (acc |-> pready_out)
    else $error("Access phase without ready.");
  a_reserved_zero: assert property (acc && !pwrite_in && paddr_in == 12'h1F0
    |-> prdata_out[7:6] == 2'b00) else $error("Reserved capture bits set.");
  a_upper_bytes: assert property (acc && !pwrite_in |-> prdata_out[31:8] == 24'h000000)
    else $error("Read data above bit 7 not zero.");
  a_enable_follow: assert property (acc && pwrite_in && paddr_in == 12'h1E0
    |=> wave_oe_out == $past(pwdata_in[7:4])) else $error("Enables do not follow write.");
  a_off_low: assert property ((~wave_oe_out & ~$past(wave_oe_out) & wave_out) == '0)
    else $error("Disabled output driven high.");
  a_cap1_clear: assert property (acc && !pwrite_in && paddr_in == 12'h1F4
    && capture_irq_out[0] |=> !capture_irq_out[0])
    else $error("Capture one request not cleared.");
  a_cap2_clear: assert property (acc && !pwrite_in && paddr_in == 12'h1F8
    && capture_irq_out[1] |=> !capture_irq_out[1])
    else $error("Capture two request not cleared.");
  a_cap_hold: assert property (capture_irq_out[0] && !(acc && paddr_in[11:4] == 8'h1F)
    |=> capture_irq_out[0]) else $error("Capture request dropped alone.");
  a_wrap_hold: assert property (wrap_irq_out && !(acc && paddr_in == 12'h1E4)
    |=> wrap_irq_out) else $error("Wrap request dropped alone.");
  a_reset_quiet: assert property ($rose(nrst_in) |-> wave_oe_out == '0 && !wrap_irq_out
    && capture_irq_out == '0) else $error("Outputs active after reset.");
  a_unmapped_err: assert property (acc && paddr_in > 12'h1F8 |-> pslverr_out)
    else $error("Unmapped access without error.");
endmodule

bind pwmt_timer pwmt_monitor #(.CHANNELS(CHANNELS), .CAPTURES(CAPTURES)) u_mon (
  .mclk_in(mclk_in), .nrst_in(nrst_in), .psel_in(psel_in), .penable_in(penable_in),
  .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .prdata_out(prdata_out),
  .ext_clk_in(ext_clk_in), .capture_pin_in(capture_pin_in), .wave_out(wave_out),
  .wave_oe_out(wave_oe_out), .wrap_irq_out(wrap_irq_out),
  .capture_irq_out(capture_irq_out));

// File: pwmt_timer.v
`timescale 1ns/1ps
`include "pwmt_map.vh"

// Summary of operation
// - Counter readable live, writable through count register.
// - Overflow reloads counter from reload value.
// - Overflow switches outputs per channel polarity.
// - Reload value sets period and duty resolution.
// - Upper nibble enables each output pin.
// - Lower nibble sets polarity; zero high at/below compare.
// - Polarity change inverts output the next cycle, without waiting for overflow.
// - Per-channel duty register gives second edge.
// - Capture status bits 7:6 read zero.
// - Edge bit: 0 falling, 1 rising.
// - Per-channel capture interrupt enables.
// - Capture flag set by hardware, cleared reading capture.
// - Capture registers latch counter, ignore writes.
// - All registers reset to zero.
// - Count write or forced reload clears prescaler.
// - Compare values reload from duty only at overflow.
// - Compare match restores pre-overflow output level.
// - Capture blocked until capture register read.
module pwmt_timer #(
  parameter CHANNELS = 4,           // Number of waveform outputs.
  parameter CAPTURES = 2            // Number of capture channels.
) (
  // Clock and reset.
  input  wire                mclk_in,
  input  wire                nrst_in,
  // APB slave.
  input  wire                psel_in,
  input  wire                penable_in,
  input  wire                pwrite_in,
  input  wire [11:0]         paddr_in,
  input  wire [31:0]         pwdata_in,
  output wire                pready_out,
  output wire                pslverr_out,
  output wire [31:0]         prdata_out,
  // Timer pins.
  input  wire                ext_clk_in,
  input  wire [CAPTURES-1:0] capture_pin_in,
  output wire [CHANNELS-1:0] wave_out,
  output wire [CHANNELS-1:0] wave_oe_out,
  // Interrupt requests.
  output wire                wrap_irq_out,
  output wire [CAPTURES-1:0] capture_irq_out
);

  // ========================================================================
  // Helper functions
  // ========================================================================

  // Returns the prescaler mask for a division select of 0 to 7.
  function [6:0] pwmt_div_mask;
    input [2:0] sel;
    begin
      pwmt_div_mask = 7'h7F >> (3'h7 - sel);
      if (sel == 3'h0) begin
        pwmt_div_mask = 7'h00;
      end
    end
  endfunction

  // Turns a word byte address into a register index, flagging misalignment.
  function [8:0] pwmt_index;
    input [11:0] addr;
    begin
      pwmt_index = {(addr[1:0] != 2'h0) | (addr[11:10] != 2'h0), addr[9:2]};
    end
  endfunction

  // Returns the register index of one duty channel; channel zero sits highest.
  function [8:0] pwmt_duty_index;
    input integer ch;
    begin
      pwmt_duty_index = {1'b0, `PWMT_IDX_DUTY0} - ch[8:0];
    end
  endfunction

  // ========================================================================
  // Storage
  // ========================================================================
  reg  [7:0]          duty_level_reg [0:CHANNELS-1];  // Software duty values.
  reg  [7:0]          compare_value_reg [0:CHANNELS-1]; // Buffered compares.
  reg  [7:0]          wave_output_control_reg;        // Enables and polarity.
  reg                 ext_sel_reg;                    // External clock select.
  reg  [2:0]          div_sel_reg;                    // Prescaler division.
  reg                 run_reg;                        // Counter enable.
  reg                 wrap_irq_en_reg;                // Overflow request enable.
  reg                 wrap_flag_reg;                  // Overflow flag.
  reg  [7:0]          count_reg;                      // Running counter.
  reg  [7:0]          reload_value_reg;               // Auto-reload value.
  reg  [CAPTURES-1:0] capture_edge_reg;               // Edge selects.
  reg  [CAPTURES-1:0] capture_irq_en_reg;             // Capture request enables.
  reg  [CAPTURES-1:0] capture_flag_reg;               // Capture flags.
  reg  [7:0]          captured_count_reg [0:CAPTURES-1]; // Latched counts.
  reg  [6:0]          presc_reg;                      // Seven-bit prescaler.
  reg                 ext_prev_reg;                   // Last external clock.
  reg  [CAPTURES-1:0] capt_prev_reg;                  // Last capture pin levels.
  reg  [CHANNELS-1:0] wave_reg;                       // Registered pin levels.
  reg  [31:0]         rdata_reg;                      // Read data.
  reg                 err_reg;                        // Unmapped flag for access.

  // ========================================================================
  // Bus decode
  // ========================================================================
  wire       setup_ph   = psel_in & ~penable_in;      // Setup cycle.
  wire       access_ph  = psel_in & penable_in;       // Access cycle, completes.
  wire [8:0] idx        = pwmt_index(paddr_in);       // Index with bad bit.
  wire       wr_go      = access_ph & pwrite_in & ~err_reg;
  wire       rd_go      = access_ph & ~pwrite_in & ~err_reg;
  wire [7:0] wb         = pwdata_in[7:0];             // Written byte.

  // Strobes for registers with side effects.
  wire wr_count  = wr_go & (idx == {1'b0, `PWMT_IDX_COUNT});
  wire wr_tcs    = wr_go & (idx == {1'b0, `PWMT_IDX_TIMER_CS});
  wire force_rl  = wr_tcs & wb[`PWMT_TCS_FORCE];
  wire rd_tcs    = rd_go & (idx == {1'b0, `PWMT_IDX_TIMER_CS});
  wire [CAPTURES-1:0] rd_capt;
  assign rd_capt[0] = rd_go & (idx == {1'b0, `PWMT_IDX_CAPT1});
  assign rd_capt[1] = rd_go & (idx == {1'b0, `PWMT_IDX_CAPT2});

  // Zero-wait slave: the access cycle always completes.
  assign pready_out  = access_ph;
  assign pslverr_out = access_ph & err_reg;
  assign prdata_out  = rdata_reg;

  // ========================================================================
  // Read data mux
  // ========================================================================

  // Selects the addressed register; unmapped indices read zero.
  reg [7:0] rd_byte;
  reg       rd_bad;
  always @* begin
    rd_byte = 8'h00;
    rd_bad  = 1'b0;
    case (idx)
      {1'b0, `PWMT_IDX_DUTY3}:     rd_byte = duty_level_reg[3];
      {1'b0, `PWMT_IDX_DUTY2}:     rd_byte = duty_level_reg[2];
      {1'b0, `PWMT_IDX_DUTY1}:     rd_byte = duty_level_reg[1];
      {1'b0, `PWMT_IDX_DUTY0}:     rd_byte = duty_level_reg[0];
      {1'b0, `PWMT_IDX_WAVE_CTRL}: rd_byte = wave_output_control_reg;
      {1'b0, `PWMT_IDX_TIMER_CS}: begin
        // The force bit always reads zero.
        rd_byte = {ext_sel_reg, div_sel_reg, run_reg, 1'b0, wrap_irq_en_reg,
                   wrap_flag_reg};
      end
      {1'b0, `PWMT_IDX_COUNT}:     rd_byte = count_reg;
      {1'b0, `PWMT_IDX_RELOAD}:    rd_byte = reload_value_reg;
      {1'b0, `PWMT_IDX_CAPT_CS}: begin
        // Top two bits are reserved zero.
        rd_byte = {2'b00, capture_edge_reg, capture_irq_en_reg,
                   capture_flag_reg};
      end
      {1'b0, `PWMT_IDX_CAPT1}:     rd_byte = captured_count_reg[0];
      {1'b0, `PWMT_IDX_CAPT2}:     rd_byte = captured_count_reg[1];
      default: begin
        rd_bad = 1'b1;
      end
    endcase
  end

  // Captures read data and the error status in the setup cycle.
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
    end else if (setup_ph) begin
      rdata_reg <= {24'h00_0000, rd_byte};
      err_reg   <= rd_bad;
    end
  end

  // ========================================================================
  // Prescaler and tick generation
  // ========================================================================

  // The input event is a CPU cycle, or a rising external clock edge.
  wire       in_tick  = run_reg & (~ext_sel_reg | (ext_clk_in & ~ext_prev_reg));
  wire [6:0] mask     = pwmt_div_mask(div_sel_reg);
  wire       cnt_tick = in_tick & ((presc_reg & mask) == mask);
  wire       wrap     = cnt_tick & (count_reg == `PWMT_CNT_TOP);

  // Prescaler; clears on counter write or forced reload.
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      presc_reg    <= `PWMT_PRE_RST;
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_clk_in;
      if (wr_count | force_rl) begin
        presc_reg <= `PWMT_PRE_RST;
      end else if (in_tick) begin
        presc_reg <= presc_reg + 7'h01;
      end
    end
  end

  // ========================================================================
  // Counter and control registers
  // ========================================================================

  // Software writes, counter stepping and overflow flag.
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wave_output_control_reg <= `PWMT_RST_BYTE;
      ext_sel_reg      <= 1'b0;
      div_sel_reg      <= 3'h0;
      run_reg          <= 1'b0;
      wrap_irq_en_reg  <= 1'b0;
      wrap_flag_reg    <= 1'b0;
      count_reg        <= `PWMT_RST_BYTE;
      reload_value_reg <= `PWMT_RST_BYTE;
    end else begin
      if (wr_go && idx == {1'b0, `PWMT_IDX_WAVE_CTRL}) begin
        wave_output_control_reg <= wb;
      end
      if (wr_go && idx == {1'b0, `PWMT_IDX_RELOAD}) begin
        reload_value_reg <= wb;
      end
      if (wr_tcs) begin
        ext_sel_reg     <= wb[`PWMT_TCS_EXT];
        div_sel_reg     <= wb[`PWMT_TCS_DIV_HI:`PWMT_TCS_DIV_LO];
        run_reg         <= wb[`PWMT_TCS_RUN];
        wrap_irq_en_reg <= wb[`PWMT_TCS_WIE];
      end
      // Overflow sets the flag; a same-cycle read-clear loses.
      if (wrap) begin
        wrap_flag_reg <= 1'b1;
      end else if (rd_tcs) begin
        wrap_flag_reg <= 1'b0;
      end
      // Direct load wins over counting.
      if (wr_count) begin
        count_reg <= wb;
      end else if (force_rl) begin
        count_reg <= reload_value_reg;
      end else if (wrap) begin
        count_reg <= reload_value_reg;
      end else if (cnt_tick) begin
        count_reg <= count_reg + 8'h01;
      end
    end
  end

  // ========================================================================
  // Waveform channels
  // ========================================================================
  genvar gi;
  generate
    for (gi = 0; gi < CHANNELS; gi = gi + 1) begin : g_ch
      // Duty write, and compare reload only at overflow.
      always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          duty_level_reg[gi]    <= `PWMT_RST_BYTE;
          compare_value_reg[gi] <= `PWMT_RST_BYTE;
        end else begin
          if (wr_go && idx == pwmt_duty_index(gi)) begin
            duty_level_reg[gi] <= wb;
          end
          if (wrap) begin
            compare_value_reg[gi] <= duty_level_reg[gi];
          end
        end
      end

      // Level follows counter against compare, flipped by polarity.
      wire pol = wave_output_control_reg[`PWMT_WC_POL_LO + gi];
      wire en  = wave_output_control_reg[`PWMT_WC_OE_LO + gi];
      always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          wave_reg[gi] <= 1'b0;
        end else begin
          // Overflow starts the active level, passing compare restores it;
          // polarity takes effect the next cycle without waiting.
          wave_reg[gi] <= en & ((count_reg <= compare_value_reg[gi]) ^ pol);
        end
      end
      assign wave_oe_out[gi] = en;
    end
  endgenerate

  assign wave_out     = wave_reg;
  assign wrap_irq_out = wrap_flag_reg & wrap_irq_en_reg;

  // ========================================================================
  // Capture control register
  // ========================================================================

  // Edge selects and interrupt enables are plain software bits.
  always @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      capture_edge_reg   <= {CAPTURES{1'b0}};
      capture_irq_en_reg <= {CAPTURES{1'b0}};
      capt_prev_reg      <= {CAPTURES{1'b0}};
    end else begin
      capt_prev_reg <= capture_pin_in;
      if (wr_go && idx == {1'b0, `PWMT_IDX_CAPT_CS}) begin
        capture_edge_reg   <= wb[`PWMT_CCS_EDGE_HI:`PWMT_CCS_EDGE_LO];
        capture_irq_en_reg <= wb[`PWMT_CCS_IE_HI:`PWMT_CCS_IE_LO];
      end
    end
  end

  // ========================================================================
  // Capture channels
  // ========================================================================
  generate
    for (gi = 0; gi < CAPTURES; gi = gi + 1) begin : g_cap
      // Rising edge when the select is one, falling edge otherwise.
      wire rise = capture_pin_in[gi] & ~capt_prev_reg[gi];
      wire fall = ~capture_pin_in[gi] & capt_prev_reg[gi];
      wire hit  = capture_edge_reg[gi] ? rise : fall;

      // Latch and flag; a pending flag blocks further captures.
      always @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          captured_count_reg[gi] <= `PWMT_RST_BYTE;
          capture_flag_reg[gi]   <= 1'b0;
        end else begin
          if (hit && !capture_flag_reg[gi]) begin
            captured_count_reg[gi] <= count_reg;
            capture_flag_reg[gi]   <= 1'b1;
          end else if (rd_capt[gi]) begin
            capture_flag_reg[gi] <= 1'b0;
          end
        end
      end

      assign capture_irq_out[gi] = capture_flag_reg[gi] & capture_irq_en_reg[gi];
    end
  endgenerate

endmodule

// File: test_pwmt_timer.sv
`timescale 1ns/1ps
`include "pwmt_map.vh"
// ==========================================================================
// Compare helpers; port values are looked at mid-cycle.
// ==========================================================================
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
  $display("Error at %0t: got %0h expected %0h", $time, g, e); end end
`define PCHK(g, e) begin @(negedge mclk_in); `CHK(g, e) @(posedge mclk_in); end
module test_pwmt_timer;
  logic        mclk_in = 0;  // Bus clock.
  logic        nrst_in = 0;  // Reset, active low.
  logic        psel    = 0;  // Bus select.
  logic        penable = 0;  // Bus access phase.
  logic        pwrite  = 0;  // Bus direction.
  logic [11:0] paddr   = 0;  // Bus byte address.
  logic [31:0] pwdata  = 0;  // Bus write data.
  logic        ext_clk = 0;  // External count clock.
  logic [1:0]  cap_pin = 2'b10;  // Capture pins.
  wire         pready, pslverr, wrap_irq;
  wire  [31:0] prdata;
  wire  [3:0]  wave, wave_oe;
  wire  [1:0]  cap_irq;
  logic [7:0]  rd;  // Last read byte.
  logic        err;  // Last error response.
  int          n_fail = 0;
  int          tests_run = 0;

  pwmt_timer dut (.mclk_in(mclk_in), .nrst_in(nrst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata),
    .ext_clk_in(ext_clk), .capture_pin_in(cap_pin), .wave_out(wave),
    .wave_oe_out(wave_oe), .wrap_irq_out(wrap_irq), .capture_irq_out(cap_irq));

  // Free-running 40 MHz clock.
  always #12.5 mclk_in = ~mclk_in;

  // Print the counts and the verdict, then stop.
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One bus transfer; the byte address is four times the index.
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge mclk_in);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge mclk_in);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1) begin
      n_fail++;
      finish_test;
    end else begin
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk_in);
    end
  endtask

  // Write a register.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d);
  endtask

  // Read a register and compare it.
  task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
    xfer(1'b0, idx, 8'h00);
    `CHK(rd, e)
  endtask

  // Give the counter n external clock rises.
  task automatic tick(input int n);
    repeat (n) begin
      ext_clk <= 1'b1;
      repeat (2) @(posedge mclk_in);
      ext_clk <= 1'b0;
      repeat (2) @(posedge mclk_in);
    end
  endtask

  // Set the capture pins and let the edge be seen.
  task automatic pins(input logic [1:0] v);
    cap_pin <= v;
    repeat (3) @(posedge mclk_in);
  endtask

  // Main sequence.
  initial begin
    repeat (5) @(posedge mclk_in);
    nrst_in <= 1'b1;
    @(posedge mclk_in);
    for (int i = 8'h74; i <= 8'h7E; i++) rchk(i[7:0], 8'h00);
    xfer(1'b0, 8'h7F, 8'h00);
    `CHK({err, rd}, 9'h100)
    for (int i = 8'h74; i <= 8'h77; i++) begin
      wr(i[7:0], i[7:0] ^ 8'h5A);
      rchk(i[7:0], i[7:0] ^ 8'h5A);
    end
    wr(`PWMT_IDX_CAPT1, 8'hFF);
    rchk(`PWMT_IDX_CAPT1, 8'h00);
    $display("Test registers done");
    wr(`PWMT_IDX_RELOAD, 8'h40);
    wr(`PWMT_IDX_COUNT, 8'hFE);
    rchk(`PWMT_IDX_COUNT, 8'hFE);
    wr(`PWMT_IDX_TIMER_CS, 8'h8A);
    tick(2);
    `PCHK(wrap_irq, 1'b1)
    rchk(`PWMT_IDX_COUNT, 8'h40);
    rchk(`PWMT_IDX_TIMER_CS, 8'h8B);
    `PCHK(wrap_irq, 1'b0)
    tick(1);
    wr(`PWMT_IDX_TIMER_CS, 8'h8C);
    rchk(`PWMT_IDX_COUNT, 8'h40);
    // Divide by two: a count write must drop the half-done prescaler step.
    wr(`PWMT_IDX_TIMER_CS, 8'h98);
    tick(1);
    wr(`PWMT_IDX_COUNT, 8'h10);
    tick(1);
    rchk(`PWMT_IDX_COUNT, 8'h10);
    tick(1);
    rchk(`PWMT_IDX_COUNT, 8'h11);
    wr(`PWMT_IDX_TIMER_CS, 8'h88);
    $display("Test counter done");
    wr(`PWMT_IDX_RELOAD, 8'h7E);
    wr(`PWMT_IDX_DUTY0, 8'h80);
    wr(`PWMT_IDX_WAVE_CTRL, 8'h10);
    `PCHK(wave_oe, 4'h1)
    wr(`PWMT_IDX_COUNT, 8'h50);
    `PCHK(wave[0], 1'b0)
    wr(`PWMT_IDX_COUNT, 8'hFF);
    tick(1);
    `PCHK(wave, 4'h1)
    tick(2);
    `PCHK(wave[0], 1'b1)
    tick(1);
    `PCHK(wave[0], 1'b0)
    wr(`PWMT_IDX_WAVE_CTRL, 8'h11);
    `PCHK(wave[0], 1'b1)
    wr(`PWMT_IDX_WAVE_CTRL, 8'hFA);
    `PCHK({wave_oe, wave}, 8'hFA)
    wr(`PWMT_IDX_WAVE_CTRL, 8'h01);
    `PCHK({wave_oe, wave}, 8'h00)
    $display("Test waveform done");
    wr(`PWMT_IDX_TIMER_CS, 8'h00);
    wr(`PWMT_IDX_COUNT, 8'h33);
    wr(`PWMT_IDX_CAPT_CS, 8'h1C);
    pins(2'b11);
    `PCHK(cap_irq, 2'b01)
    pins(2'b01);
    `PCHK(cap_irq, 2'b11)
    wr(`PWMT_IDX_COUNT, 8'h55);
    pins(2'b00);
    pins(2'b01);
    rchk(`PWMT_IDX_CAPT_CS, 8'h1F);
    rchk(`PWMT_IDX_CAPT1, 8'h33);
    `PCHK(cap_irq, 2'b10)
    rchk(`PWMT_IDX_CAPT2, 8'h33);
    wr(`PWMT_IDX_CAPT_CS, 8'h10);
    pins(2'b00);
    pins(2'b01);
    `PCHK(cap_irq, 2'b00)
    rchk(`PWMT_IDX_CAPT_CS, 8'h11);
    rchk(`PWMT_IDX_CAPT1, 8'h55);
    $display("Test capture done");
    // Reset in mid-run must clear live enables and latched captures.
    wr(`PWMT_IDX_WAVE_CTRL, 8'hF0);
    nrst_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    nrst_in <= 1'b1;
    @(posedge mclk_in);
    `PCHK({wave_oe, wave, cap_irq}, 10'h000)
    rchk(`PWMT_IDX_WAVE_CTRL, 8'h00);
    rchk(`PWMT_IDX_CAPT1, 8'h00);
    $display("Test reset done");
    finish_test;
  end
endmodule
